// ==== sawd_pkg.sv ====
// Notes on behaviour
// R1 - busy reads 1 during low-power tracking and during conversion; in edge-start mode tracking follows the pin and busy stays 0
// R2 - done flag sets on busy fall, sticky
// R3 - low-power code 11: timer2 tracks 3 clocks
// R4 - low-power code 01: timer3 tracks 3 clocks
// R5 - window flag sets when result matches window
// R6 - window flag sticky, cleared only by software
// R7 - every result compared, no software per conversion
// R8 - limits held as separately writable byte pairs
// R9 - limit ordering picks inside or outside window
// R10 - window flag readable by polling
// R11 - start code picks sw, timer3, edge, timer2
// R12 - enable clear shuts down, ignores triggers
package sawd_pkg;
   localparam logic [7:0] CTRL_ADDR = 8'hE8;
   localparam logic [7:0] UL_LO_ADDR = 8'hC4;
   localparam logic [7:0] UL_HI_ADDR = 8'hC5;
   localparam logic [7:0] LL_LO_ADDR = 8'hC6;
   localparam logic [7:0] LL_HI_ADDR = 8'hC7;
   localparam int EN_BIT = 7;
   localparam int TM_BIT = 6;
   localparam int DONE_BIT = 5;
   localparam int BUSY_BIT = 4;
   localparam int CM_HI_BIT = 3;
   localparam int CM_LO_BIT = 2;
   localparam int WIN_BIT = 1;
   localparam int LJST_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] UL_RESET = 8'hFF;
   localparam logic [7:0] LL_RESET = 8'h00;
   localparam logic [1:0] START_SW = 2'h0;
   localparam logic [1:0] START_T3 = 2'h1;
   localparam logic [1:0] START_EXT = 2'h2;
   localparam logic [1:0] START_T2 = 2'h3;
   localparam logic [1:0] TRACK_SAR_CLKS = 2'h3;
   localparam int DATA_W = 16;
   typedef enum logic [1:0] {SAWD_IDLE, SAWD_TRACK, SAWD_CONV} sawd_state_e;
endpackage

// ==== sawd_window.sv ====
`timescale 1ns/1ns
module sawd_window #(
   parameter int W = 16
) (
   input wire logic [W-1:0] data_i,
   input wire logic [W-1:0] upper_i,
   input wire logic [W-1:0] lower_i,
   output logic match_o
);
   always_comb
   begin
      // less-than limit above greater-than limit means an inside window
      if (lower_i > upper_i)
         match_o = (data_i > upper_i) && (data_i < lower_i); // R9
      else
         match_o = (data_i > upper_i) || (data_i < lower_i); // R9
   end
endmodule // sawd_window

// ==== sawd_top.sv ====
`timescale 1ns/1ns
module sawd_top #(
   parameter int RES_W = 12,
   parameter int SAR_DIV = 2
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic timer2_ovf_i,
   input wire logic timer3_ovf_i,
   input wire logic external_start_input_i,
   input wire logic core_done_i,
   input wire logic [RES_W-1:0] core_result_i,
   output logic core_enable_o,
   output logic core_track_o,
   output logic core_start_o,
   output logic [sawd_pkg::DATA_W-1:0] result_o,
   output logic conversion_done_flag_o,
   output logic window_match_flag_o
);
   localparam int DW = sawd_pkg::DATA_W;
   localparam int PAD = DW - RES_W;

   sawd_pkg::sawd_state_e state_q, state_d;
   logic converter_enable_q, track_mode_select_q, result_justify_select_q;
   logic [1:0] start_source_select_q;
   logic conversion_done_flag_q, window_match_flag_q;
   logic busy_prev_q, ext_prev_q, start_q;
   logic [1:0] trk_cnt_q;
   logic [$clog2(SAR_DIV+1)-1:0] div_q;
   logic sar_tick;
   logic [DW-1:0] upper_q, lower_q, result_q, justified;
   logic [7:0] rdata_d;
   logic conversion_busy, busy_fall, ext_rise, sw_start, trigger, match, result_take;
   logic ctrl_wr;

   assign ctrl_wr = sfr_wr_i && (sfr_addr_i == sawd_pkg::CTRL_ADDR);
   assign sw_start = ctrl_wr && sfr_wdata_i[sawd_pkg::BUSY_BIT];
   assign ext_rise = external_start_input_i && !ext_prev_q;
   assign conversion_busy = (state_q != sawd_pkg::SAWD_IDLE); // R1
   assign busy_fall = busy_prev_q && !conversion_busy;
   assign result_take = core_done_i && (state_q == sawd_pkg::SAWD_CONV);
   assign justified = result_justify_select_q ? {core_result_i, {PAD{1'b0}}}
                                              : {{PAD{1'b0}}, core_result_i};

   always_comb
   begin
      case (start_source_select_q) // R11
         sawd_pkg::START_SW: trigger = sw_start;
         sawd_pkg::START_T3: trigger = timer3_ovf_i;
         sawd_pkg::START_EXT: trigger = ext_rise;
         sawd_pkg::START_T2: trigger = timer2_ovf_i;
         default: trigger = 1'b0;
      endcase
   end

   // sar clock as an enable; held in reset while shut down to save power
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         div_q <= '0;
      else if (!converter_enable_q || div_q == ($clog2(SAR_DIV+1))'(SAR_DIV - 1))
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
   end
   assign sar_tick = converter_enable_q && (div_q == ($clog2(SAR_DIV+1))'(SAR_DIV - 1));

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         sawd_pkg::SAWD_IDLE:
            if (trigger)
            begin
               // edge-started low-power mode tracks on the pin level instead
               if (track_mode_select_q && start_source_select_q != sawd_pkg::START_EXT)
                  state_d = sawd_pkg::SAWD_TRACK; // R3 R4
               else
                  state_d = sawd_pkg::SAWD_CONV; // R11
            end
         sawd_pkg::SAWD_TRACK:
            if (sar_tick && trk_cnt_q == sawd_pkg::TRACK_SAR_CLKS - 2'h1)
               state_d = sawd_pkg::SAWD_CONV; // R3 R4
         sawd_pkg::SAWD_CONV:
            if (core_done_i)
               state_d = sawd_pkg::SAWD_IDLE; // R1
         default: state_d = sawd_pkg::SAWD_IDLE;
      endcase
      if (!converter_enable_q)
         state_d = sawd_pkg::SAWD_IDLE; // R12
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_q <= sawd_pkg::SAWD_IDLE;
         start_q <= 1'b0;
         busy_prev_q <= 1'b0;
         // start pin idles high; a zero here would fake a rising edge after reset
         ext_prev_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         start_q <= (state_d == sawd_pkg::SAWD_CONV) && (state_q != sawd_pkg::SAWD_CONV);
         busy_prev_q <= conversion_busy;
         ext_prev_q <= external_start_input_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         trk_cnt_q <= 2'h0;
      else if (state_q != sawd_pkg::SAWD_TRACK)
         trk_cnt_q <= 2'h0;
      else if (sar_tick)
         trk_cnt_q <= trk_cnt_q + 2'h1; // R3 R4
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         converter_enable_q <= sawd_pkg::CTRL_RESET[sawd_pkg::EN_BIT];
         track_mode_select_q <= sawd_pkg::CTRL_RESET[sawd_pkg::TM_BIT];
         start_source_select_q <= sawd_pkg::CTRL_RESET[sawd_pkg::CM_HI_BIT:sawd_pkg::CM_LO_BIT];
         result_justify_select_q <= sawd_pkg::CTRL_RESET[sawd_pkg::LJST_BIT];
      end
      else if (ctrl_wr)
      begin
         converter_enable_q <= sfr_wdata_i[sawd_pkg::EN_BIT]; // R12
         track_mode_select_q <= sfr_wdata_i[sawd_pkg::TM_BIT];
         start_source_select_q <= sfr_wdata_i[sawd_pkg::CM_HI_BIT:sawd_pkg::CM_LO_BIT];
         result_justify_select_q <= sfr_wdata_i[sawd_pkg::LJST_BIT];
      end
   end

   // hardware set beats a software clear landing in the same cycle
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         conversion_done_flag_q <= sawd_pkg::CTRL_RESET[sawd_pkg::DONE_BIT];
      else if (busy_fall)
         conversion_done_flag_q <= 1'b1; // R2
      else if (ctrl_wr)
         conversion_done_flag_q <= sfr_wdata_i[sawd_pkg::DONE_BIT];
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         window_match_flag_q <= sawd_pkg::CTRL_RESET[sawd_pkg::WIN_BIT];
      else if (result_take && match)
         window_match_flag_q <= 1'b1; // R5 R7
      else if (ctrl_wr)
         window_match_flag_q <= sfr_wdata_i[sawd_pkg::WIN_BIT]; // R6
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         upper_q <= {sawd_pkg::UL_RESET, sawd_pkg::UL_RESET};
         lower_q <= {sawd_pkg::LL_RESET, sawd_pkg::LL_RESET};
      end
      else if (sfr_wr_i)
      begin
         case (sfr_addr_i) // R8
            sawd_pkg::UL_HI_ADDR: upper_q[15:8] <= sfr_wdata_i;
            sawd_pkg::UL_LO_ADDR: upper_q[7:0] <= sfr_wdata_i;
            sawd_pkg::LL_HI_ADDR: lower_q[15:8] <= sfr_wdata_i;
            sawd_pkg::LL_LO_ADDR: lower_q[7:0] <= sfr_wdata_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         result_q <= '0;
      else if (result_take)
         result_q <= justified; // R7
   end

   sawd_window #(.W(DW)) u_window (
      .data_i(justified),
      .upper_i(upper_q),
      .lower_i(lower_q),
      .match_o(match)
   );

   always_comb
   begin
      case (sfr_addr_i)
         sawd_pkg::CTRL_ADDR: rdata_d = {converter_enable_q, track_mode_select_q,
                                         conversion_done_flag_q, conversion_busy,
                                         start_source_select_q, window_match_flag_q,
                                         result_justify_select_q}; // R10
         sawd_pkg::UL_HI_ADDR: rdata_d = upper_q[15:8];
         sawd_pkg::UL_LO_ADDR: rdata_d = upper_q[7:0];
         sawd_pkg::LL_HI_ADDR: rdata_d = lower_q[15:8];
         sawd_pkg::LL_LO_ADDR: rdata_d = lower_q[7:0];
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         sfr_rdata_o <= 8'h00;
      else
         sfr_rdata_o <= rdata_d;
   end

   assign core_enable_o = converter_enable_q;
   assign core_start_o = start_q;
   assign result_o = result_q;
   assign conversion_done_flag_o = conversion_done_flag_q;
   assign window_match_flag_o = window_match_flag_q;
   always_comb
   begin
      if (!converter_enable_q)
         core_track_o = 1'b0;
      else if (!track_mode_select_q)
         core_track_o = (state_q == sawd_pkg::SAWD_IDLE);
      else if (start_source_select_q == sawd_pkg::START_EXT)
         core_track_o = (state_q == sawd_pkg::SAWD_IDLE) && !external_start_input_i;
      else
         core_track_o = (state_q == sawd_pkg::SAWD_TRACK);
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   busy_after_done_a: assert property (result_take |=> !conversion_busy) // R1
      else $error("busy still set after conversion end");
   done_on_fall_a: assert property ($fell(conversion_busy) |=> conversion_done_flag_q) // R2
      else $error("done flag not set on busy fall");
   done_sticky_a: assert property (conversion_done_flag_q && !ctrl_wr |=> conversion_done_flag_q) // R2
      else $error("done flag dropped without software");
   t2_track_a: assert property (converter_enable_q && track_mode_select_q
      && start_source_select_q == sawd_pkg::START_T2 && state_q == sawd_pkg::SAWD_IDLE
      && timer2_ovf_i |=> state_q == sawd_pkg::SAWD_TRACK && core_track_o) // R3
      else $error("timer2 did not start tracking");
   t3_track_a: assert property (converter_enable_q && track_mode_select_q
      && start_source_select_q == sawd_pkg::START_T3 && state_q == sawd_pkg::SAWD_IDLE
      && timer3_ovf_i |=> state_q == sawd_pkg::SAWD_TRACK) // R4
      else $error("timer3 did not start tracking");
   track_len_a: assert property (state_q == sawd_pkg::SAWD_CONV
      && $past(state_q) == sawd_pkg::SAWD_TRACK |-> $past(trk_cnt_q) == 2'h2 && core_start_o) // R3
      else $error("tracking phase not three sar clocks");
   win_set_a: assert property (result_take && (lower_q > upper_q) && (justified > upper_q)
      && (justified < lower_q) |=> window_match_flag_q) // R9
      else $error("inside window match missed");
   win_out_a: assert property (result_take && (lower_q <= upper_q) && (justified < lower_q)
      |=> window_match_flag_q) // R5
      else $error("outside window match missed");
   win_sticky_a: assert property (window_match_flag_q && !ctrl_wr |=> window_match_flag_q) // R6
      else $error("window flag cleared by hardware");
   result_latch_a: assert property (result_take |=> result_o == $past(justified)) // R7
      else $error("result not captured");
   limit_write_a: assert property (sfr_wr_i && sfr_addr_i == sawd_pkg::LL_HI_ADDR
      |=> lower_q[15:8] == $past(sfr_wdata_i)) // R8
      else $error("limit byte not written");
   win_poll_a: assert property (sfr_addr_i == sawd_pkg::CTRL_ADDR
      |=> sfr_rdata_o[sawd_pkg::WIN_BIT] == $past(window_match_flag_q)) // R10
      else $error("window flag not readable");
   t3_normal_a: assert property (converter_enable_q && !track_mode_select_q
      && start_source_select_q == sawd_pkg::START_T3 && state_q == sawd_pkg::SAWD_IDLE
      && timer3_ovf_i |=> core_start_o && conversion_busy) // R11
      else $error("timer3 did not start conversion");
   off_idle_a: assert property (!converter_enable_q |=> state_q == sawd_pkg::SAWD_IDLE) // R12
      else $error("disabled converter not idle");

   normal_conv_c: cover property (start_q ##[1:50] result_take);
   lowpwr_track_c: cover property (state_q == sawd_pkg::SAWD_TRACK ##[1:20] start_q);
   window_hit_c: cover property ($rose(window_match_flag_q));
endmodule // sawd_top

// ==== sawd_core_model.sv ====
`timescale 1ns/1ns
module sawd_core_model (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic start_i,
   input wire logic enable_i,
   input wire logic [11:0] data_i,
   input wire logic [7:0] wait_i,
   output logic done_o,
   output logic [11:0] result_o
);
   logic run_q;
   logic [7:0] cnt_q;
   logic [11:0] hold_q;
   // result lines toggle outside the done cycle so a stale value never looks valid
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         run_q <= 1'b0;
         cnt_q <= 8'h00;
         hold_q <= 12'h000;
         done_o <= 1'b0;
         result_o <= 12'h000;
      end
      else
      begin
         done_o <= 1'b0;
         result_o <= ~result_o;
         if (!enable_i)
            run_q <= 1'b0;
         else if (start_i)
         begin
            run_q <= 1'b1;
            cnt_q <= wait_i;
            hold_q <= data_i;
         end
         else if (run_q && cnt_q == 8'h00)
         begin
            run_q <= 1'b0;
            done_o <= 1'b1;
            result_o <= hold_q;
         end
         else if (run_q)
            cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule // sawd_core_model

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
   localparam int SD = 2;
   localparam logic [7:0] CA = sawd_pkg::CTRL_ADDR;
   logic clk = 0, rst_n = 0, swr = 0, t2 = 0, t3 = 0, ext = 1;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdata, cwait = 8'h00;
   logic [11:0] cdata = 12'h000, cres;
   logic cdone, en_o, trk, st, dflag, wflag;
   logic [15:0] res;
   logic [31:0] seed = 32'h070CD91C;
   int n_errors = 0, total_checks = 0, cyc = 0;
   bit win_e = 0;
   logic [15:0] exp_q [$];
   sawd_top #(.RES_W(12), .SAR_DIV(SD)) sawd_top_i (.core_clk_i(clk), .reset_n_i(rst_n),
      .sfr_addr_i(addr), .sfr_wr_i(swr), .sfr_wdata_i(wd), .sfr_rdata_o(rdata),
      .timer2_ovf_i(t2), .timer3_ovf_i(t3), .external_start_input_i(ext),
      .core_done_i(cdone), .core_result_i(cres), .core_enable_o(en_o), .core_track_o(trk),
      .core_start_o(st), .result_o(res), .conversion_done_flag_o(dflag),
      .window_match_flag_o(wflag));
   sawd_core_model sawd_core_model_i (.clk_i(clk), .reset_n_i(rst_n), .start_i(st),
      .enable_i(en_o), .data_i(cdata), .wait_i(cwait), .done_o(cdone), .result_o(cres));
   initial forever #2 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         finish_test();
      end
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task finish_test();
      if (n_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      swr <= 1'b1;
      @(posedge clk);
      swr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      #1 v = rdata;
   endtask
   // trigger is sampled by the design at the edge this task ends on
   task trig(input logic [1:0] code, input logic [7:0] ctl);
      case (code)
         2'h0: wr(CA, ctl | 8'h10);
         2'h1: begin @(posedge clk); t3 <= 1'b1; @(posedge clk); t3 <= 1'b0; end
         2'h2: begin @(posedge clk); ext <= 1'b0; @(posedge clk); ext <= 1'b1; @(posedge clk); end
         default: begin @(posedge clk); t2 <= 1'b1; @(posedge clk); t2 <= 1'b0; end
      endcase
   endtask
   task conv(input bit tm, input bit lj, input bit clr, input logic [1:0] code);
      logic [15:0] gt, lt, d;
      logic [7:0] v, ctl;
      logic [31:0] r;
      int tc, i;
      bit m;
      gt = 16'(rnd());
      lt = 16'(rnd());
      wr(8'hC5, gt[15:8]);
      wr(8'hC4, gt[7:0]);
      wr(8'hC7, lt[15:8]);
      wr(8'hC6, lt[7:0]);
      if (clr)
         win_e = 0;
      ctl = {1'b1, tm, ~clr, 1'b0, code, win_e, lj};
      wr(CA, ctl);
      r = rnd();
      cdata <= r[11:0];
      cwait <= {4'h0, r[15:12]};
      exp_q.push_back(lj ? {r[11:0], 4'h0} : {4'h0, r[11:0]});
      trig(code, ctl);
      tc = 0;
      #1;
      for (i = 0; i < 40 && st !== 1'b1; i++)
      begin
         tc += int'(trk);
         @(posedge clk);
         #1;
      end
      chk_out("start", 16'h0001, {15'h0000, st});
      chk_out("enable", 16'h0001, {15'h0000, en_o});
      if (tm && code != 2'h2)
         chk_out("track", 16'h0001, {15'h0000, tc >= 2 * SD + 1 && tc <= 3 * SD});
      if (r[15:12] > 4'h3)
      begin
         rd(CA, v);
         chk_reg("busy", 8'h01, {7'h00, v[4]});
      end
      for (i = 0; i < 40 && cdone !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      d = lj ? {r[11:0], 4'h0} : {4'h0, r[11:0]};
      m = (lt > gt) ? (d > gt && d < lt) : (d < lt || d > gt);
      win_e = win_e | m;
      repeat (3) @(posedge clk);
      #1;
      chk_out("result", exp_q.pop_front(), res);
      chk_out("done", 16'h0001, {15'h0000, dflag});
      chk_out("window", {15'h0000, win_e}, {15'h0000, wflag});
      chk_out("track_idle", {15'h0000, ~tm}, {15'h0000, trk});
      rd(CA, v);
      chk_reg("ctrl", {1'b1, tm, 1'b1, 1'b0, code, win_e, lj}, v);
   endtask
   logic [7:0] ra [6] = '{8'hE8, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'h00};
   logic [7:0] re [6] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
   initial
   begin
      logic [7:0] v;
      logic [31:0] r;
      int i, ns;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 6; i++)
      begin
         rd(ra[i], v);
         chk_reg("reset", re[i], v);
      end
      wr(CA, 8'h04);
      trig(2'h1, 8'h04);
      ns = 0;
      repeat (8)
      begin
         #1 ns += int'(st);
         @(posedge clk);
      end
      chk_out("no_start", 16'h0000, 16'(ns));
      wr(CA, 8'h10);
      rd(CA, v);
      chk_reg("disabled", 8'h00, v);
      wr(8'hC5, 8'h12);
      rd(8'hC5, v);
      chk_reg("gt_hi", 8'h12, v);
      rd(8'hC4, v);
      chk_reg("gt_lo", 8'hFF, v);
      for (i = 0; i < 16; i++)
      begin
         r = rnd();
         conv(i[2], r[1], i == 0 || r[2], i[1:0]);
      end
      finish_test();
   end
endmodule // testbench
